// file: rtl/acc_defines.svh
// Offsets, bit positions, reset values and lookup addresses of the auxiliary control block.
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

`define ACC_AUX_CONTROL_ADDR 8'ha2
`define ACC_AUX_CONTROL_RESET 8'h00
`define ACC_DPL_ADDR 8'h82
`define ACC_DPH_ADDR 8'h83
`define ACC_BIT_KEYPAD_FLAG 7
`define ACC_BIT_BROWNOUT_DISABLE 6
`define ACC_BIT_BROWNOUT_IRQ_MODE 5
`define ACC_BIT_LOW_POWER_PROG_MEM 4
`define ACC_BIT_SOFT_RESET 3
`define ACC_BIT_HARD_ZERO 2
`define ACC_BIT_RESERVED 1
`define ACC_BIT_POINTER_SELECT 0
`define ACC_CFG_ONE_ADDR 16'hfd00
`define ACC_CFG_TWO_ADDR 16'hfd01
`define ACC_CFG_UNPROGRAMMED 8'hff
`define ACC_SIG_ADDR_0 16'hfc30
`define ACC_SIG_ADDR_1 16'hfc31
`define ACC_SIG_ADDR_2 16'hfc60
`define ACC_CUST_FIRST 16'hfce0
`define ACC_CUST_LAST 16'hfcff
`define ACC_CUST_DEPTH 32
`define ACC_RESET_VECTOR 16'h0000
`define ACC_CFG1_WDT 7
`define ACC_CFG1_RPD 6
`define ACC_CFG1_PORT_RESET_LEVEL 5
`define ACC_CFG1_BOV 4
`define ACC_CFG1_CLOCK_HALVING_SEL 3
`define ACC_CFG2_SEC2 7
`define ACC_CFG2_SEC1 6
`define ACC_CYC_FULL 4'h6
`define ACC_CYC_HALVED 4'hc

`endif

// file: rtl/acc_pkg.sv
// Types shared by the auxiliary control block.
package acc_pkg;
   typedef enum logic [2:0] {
      ACC_OSC_HF_XTAL,
      ACC_OSC_MF_XTAL,
      ACC_OSC_LF_XTAL,
      ACC_OSC_INT_RC,
      ACC_OSC_EXT_CLK,
      ACC_OSC_RESERVED
   } acc_osc_e;
   typedef enum logic [1:0] {
      ACC_SEC_OPEN,
      ACC_SEC_NO_PROG,
      ACC_SEC_NO_VERIFY,
      ACC_SEC_UNSUPPORTED
   } acc_sec_e;
endpackage : acc_pkg

// file: rtl/acc_cfg_decode.sv
// Decoder of the two power-up configuration bytes into feature controls.
`timescale 1ns/1ps
`include "acc_defines.svh"

module acc_cfg_decode
(
   // Configuration bytes
   input wire logic [7:0] i_cfg_one,
   input wire logic [7:0] i_cfg_two,
   // Decoded controls
   output logic o_watchdog_reset_enable,
   output logic o_reset_pin_enable,
   output logic o_port_reset_level,
   output logic o_brownout_threshold_sel,
   output logic o_clock_halving,
   output logic [3:0] o_clocks_per_cycle,
   output acc_pkg::acc_osc_e o_oscillator_type,
   output acc_pkg::acc_sec_e o_security
);
   always_comb
   begin
      o_watchdog_reset_enable = i_cfg_one[`ACC_CFG1_WDT];
      o_reset_pin_enable = i_cfg_one[`ACC_CFG1_RPD];
      o_port_reset_level = i_cfg_one[`ACC_CFG1_PORT_RESET_LEVEL];
      o_brownout_threshold_sel = i_cfg_one[`ACC_CFG1_BOV];
      o_clock_halving = ~i_cfg_one[`ACC_CFG1_CLOCK_HALVING_SEL];
      o_clocks_per_cycle = o_clock_halving ? `ACC_CYC_HALVED : `ACC_CYC_FULL;
      case (i_cfg_one[2:0])
         3'h7: o_oscillator_type = acc_pkg::ACC_OSC_EXT_CLK;
         3'h3: o_oscillator_type = acc_pkg::ACC_OSC_INT_RC;
         3'h2: o_oscillator_type = acc_pkg::ACC_OSC_LF_XTAL;
         3'h1: o_oscillator_type = acc_pkg::ACC_OSC_MF_XTAL;
         3'h0: o_oscillator_type = acc_pkg::ACC_OSC_HF_XTAL;
         default: o_oscillator_type = acc_pkg::ACC_OSC_RESERVED;
      endcase
      case ({i_cfg_two[`ACC_CFG2_SEC2], i_cfg_two[`ACC_CFG2_SEC1]})
         2'h3: o_security = acc_pkg::ACC_SEC_OPEN;
         2'h2: o_security = acc_pkg::ACC_SEC_NO_PROG;
         2'h0: o_security = acc_pkg::ACC_SEC_NO_VERIFY;
         default: o_security = acc_pkg::ACC_SEC_UNSUPPORTED;
      endcase
   end
endmodule : acc_cfg_decode

// file: rtl/acc_aux_control.sv
// Auxiliary control register, dual data pointers and configuration byte access.
// What this block does
// - Keypad flag bit 7 sets on any enabled port 0 pin low; software clears.
// - Brownout disable bit 6 switches brownout detection off.
// - Brownout interrupt bit 5 turns brownout reset into an interrupt source.
// - Low-power memory bit 4 cleared only by power-on or brownout reset.
// - Writing one to bit 3 resets the processor to address 0000.
// - Bit 2 reads zero so incrementing toggles only the select bit.
// - Bit 0 selects one of two data pointers; other one hidden.
// - All pointer instructions and byte accesses use the selected pointer.
// - Reset clears the auxiliary control register to zero, except low-power bit 4.
// - Signature bytes returned for code reads at FC30h, FC31h, FC60h.
// - Customer data area FCE0h to FCFFh readable by code reads.
// - Configuration bytes readable at FD00H upward; unprogrammed reads FFH.
// - Configuration features fixed from power-up; software cannot alter them.
// - First byte bit 7 zero disables watchdog reset, interrupt still usable.
// - First byte bit 6 zero makes the reset pin an input only.
// - First byte bit 5 sets port reset level high or low.
// - First byte bit 4 selects brownout threshold 2.5 V or 3.8 V.
// - First byte bit 3 zero halves clock, twelve clocks per cycle.
// - First byte bits 2 to 0 select the oscillator type.
// - Second byte security bits block programming, then verification.
`timescale 1ns/1ps
`include "acc_defines.svh"

module acc_aux_control
#(
   parameter logic [7:0] SIG_BYTE_0 = 8'h15, // Arbitrary value.
   parameter logic [7:0] SIG_BYTE_1 = 8'h2a, // Arbitrary value.
   parameter logic [7:0] SIG_BYTE_2 = 8'h3c, // Arbitrary value.
   parameter int CUST_DEPTH = `ACC_CUST_DEPTH
)
(
   // Clock and resets
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic I_POR_OR_BOR,
   // Special function register port
   input wire logic [7:0] I_SFR_ADDR,
   input wire logic I_SFR_WR,
   input wire logic [7:0] I_SFR_WDATA,
   input wire logic I_SFR_RD,
   output logic [7:0] O_SFR_RDATA,
   // Data pointer operations
   input wire logic I_DP_INC,
   input wire logic I_DP_LOAD,
   input wire logic [15:0] I_DP_LOAD_VALUE,
   input wire logic [7:0] I_ACC,
   output logic [15:0] O_DP,
   output logic [15:0] O_DP_INDEXED,
   // Code and data memory reads through the pointer
   input wire logic I_CODE_RD,
   input wire logic [15:0] I_CODE_ADDR,
   input wire logic I_DATA_RD,
   output logic O_INFO_HIT,
   output logic [7:0] O_INFO_RDATA,
   // Customer area and configuration contents from nonvolatile memory
   input wire logic I_CUST_WR,
   input wire logic [4:0] I_CUST_WADDR,
   input wire logic [7:0] I_CUST_WDATA,
   input wire logic [7:0] I_CFG_ONE_NV,
   input wire logic [7:0] I_CFG_TWO_NV,
   input wire logic I_CFG_PROGRAMMED,
   // Events
   input wire logic [7:0] I_KEYPAD_PINS,
   input wire logic [7:0] I_KEYPAD_EN,
   input wire logic I_BROWNOUT_DET,
   // Controls to the rest of the chip
   output logic O_SOFT_RESET,
   output logic O_BROWNOUT_DET_EN,
   output logic O_BROWNOUT_RESET,
   output logic O_BROWNOUT_IRQ,
   output logic O_LOW_POWER_PROG_MEM,
   output logic O_KEYPAD_FLAG,
   output logic O_WATCHDOG_RESET_EN,
   output logic O_RESET_PIN_EN,
   output logic O_PORT_RESET_LEVEL,
   output logic O_BROWNOUT_THRESHOLD_SEL,
   output logic O_CLOCK_HALVING,
   output logic [3:0] O_CLOCKS_PER_CYCLE,
   output acc_pkg::acc_osc_e O_OSCILLATOR_TYPE,
   output acc_pkg::acc_sec_e O_SECURITY
);
   ////////////////////////////////////////////////////////////////////////////////
   // Functions.

   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   ////////////////////////////////////////////////////////////////////////////////
   // State.

   logic [7:0] aux_reg;
   logic [7:0] aux_next;
   logic lpm_reg;
   logic lpm_next;
   logic [15:0] dp_reg [2];
   logic [15:0] dp_next [2];
   logic [7:0] cust_reg [CUST_DEPTH];
   logic [7:0] cust_next [CUST_DEPTH];
   logic [7:0] cfg_one_reg;
   logic [7:0] cfg_one_next;
   logic [7:0] cfg_two_reg;
   logic [7:0] cfg_two_next;
   logic cfg_latched_reg;
   logic cfg_latched_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [7:0] info_reg;
   logic [7:0] info_next;
   logic hit_reg;
   logic hit_next;
   logic soft_reset_bit_reg;
   logic soft_reset_bit_next;
   logic [7:0] aux_view;
   logic sel;
   logic aux_wr;
   logic dph_wr;
   logic dpl_wr;

   localparam logic [7:0] SFR_DPL = `ACC_DPL_ADDR;
   localparam logic [7:0] SFR_DPH = `ACC_DPH_ADDR;

   ////////////////////////////////////////////////////////////////////////////////
   // Auxiliary control register.

   assign sel = aux_reg[`ACC_BIT_POINTER_SELECT];
   assign aux_wr = I_SFR_WR && (I_SFR_ADDR == `ACC_AUX_CONTROL_ADDR);
   assign dph_wr = I_SFR_WR && (I_SFR_ADDR == SFR_DPH);
   assign dpl_wr = I_SFR_WR && (I_SFR_ADDR == SFR_DPL);

   // The low-power bit lives beside the register because ordinary resets spare it.
   always_comb
   begin
      aux_view = aux_reg;
      aux_view[`ACC_BIT_LOW_POWER_PROG_MEM] = lpm_reg;
      aux_view[`ACC_BIT_SOFT_RESET] = 1'b0;
      aux_view[`ACC_BIT_HARD_ZERO] = 1'b0;
      aux_view[`ACC_BIT_RESERVED] = 1'b0;
   end

   always_comb
   begin
      aux_next = aux_reg;
      lpm_next = lpm_reg;
      soft_reset_bit_next = 1'b0;
      if (aux_wr)
      begin
         aux_next = I_SFR_WDATA;
         aux_next[`ACC_BIT_SOFT_RESET] = 1'b0;
         aux_next[`ACC_BIT_HARD_ZERO] = 1'b0;
         // The carry of an increment lands here, so it is dropped to keep the other bits.
         aux_next[`ACC_BIT_RESERVED] = 1'b0;
         aux_next[`ACC_BIT_LOW_POWER_PROG_MEM] = 1'b0;
         if (I_SFR_WDATA[`ACC_BIT_LOW_POWER_PROG_MEM])
         begin
            lpm_next = 1'b1;
         end
         soft_reset_bit_next = I_SFR_WDATA[`ACC_BIT_SOFT_RESET];
      end
      // A keypad event in the clearing write's cycle wins over the clear.
      if (|(I_KEYPAD_EN & ~I_KEYPAD_PINS))
      begin
         aux_next[`ACC_BIT_KEYPAD_FLAG] = 1'b1;
      end
   end

   // The soft reset request is a one-cycle pulse; the chip reset it drives
   // returns as I_SYS_RST and reinitialises all but the low-power, configuration and customer registers.
   always_ff @(posedge I_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
      begin
         aux_reg <= `ACC_AUX_CONTROL_RESET;
         soft_reset_bit_reg <= 1'b0;
      end
      else
      begin
         aux_reg <= aux_next;
         soft_reset_bit_reg <= soft_reset_bit_next;
      end
   end

   always_ff @(posedge I_CLK or posedge I_POR_OR_BOR)
   begin
      if (I_POR_OR_BOR)
      begin
         lpm_reg <= 1'b0;
      end
      else
      begin
         lpm_reg <= lpm_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Dual data pointers.

   always_comb
   begin
      dp_next = dp_reg;
      if (I_DP_LOAD)
      begin
         dp_next[sel] = I_DP_LOAD_VALUE;
      end
      else if (I_DP_INC)
      begin
         dp_next[sel] = dp_reg[sel] + 16'h0001;
      end
      else if (dph_wr)
      begin
         dp_next[sel][15:8] = I_SFR_WDATA;
      end
      else if (dpl_wr)
      begin
         dp_next[sel][7:0] = I_SFR_WDATA;
      end
   end

   always_ff @(posedge I_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
      begin
         dp_reg[0] <= 16'h0000;
         dp_reg[1] <= 16'h0000;
      end
      else
      begin
         dp_reg <= dp_next;
      end
   end

   assign O_DP = dp_reg[sel];
   assign O_DP_INDEXED = dp_reg[sel] + {8'h00, I_ACC};

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration bytes and customer area.

   // Bytes are caught once after power-up and never touched by software.
   always_comb
   begin
      cfg_one_next = cfg_one_reg;
      cfg_two_next = cfg_two_reg;
      cfg_latched_next = 1'b1;
      if (!cfg_latched_reg)
      begin
         cfg_one_next = I_CFG_PROGRAMMED ? I_CFG_ONE_NV : `ACC_CFG_UNPROGRAMMED;
         cfg_two_next = I_CFG_PROGRAMMED ? I_CFG_TWO_NV : `ACC_CFG_UNPROGRAMMED;
      end
   end

   always_ff @(posedge I_CLK or posedge I_POR_OR_BOR)
   begin
      if (I_POR_OR_BOR)
      begin
         cfg_one_reg <= `ACC_CFG_UNPROGRAMMED;
         cfg_two_reg <= `ACC_CFG_UNPROGRAMMED;
         cfg_latched_reg <= 1'b0;
      end
      else
      begin
         cfg_one_reg <= cfg_one_next;
         cfg_two_reg <= cfg_two_next;
         cfg_latched_reg <= cfg_latched_next;
      end
   end

   // Customer space is written only by the programming path, like code memory.
   always_comb
   begin
      cust_next = cust_reg;
      if (I_CUST_WR)
      begin
         cust_next[I_CUST_WADDR] = I_CUST_WDATA;
      end
   end

   always_ff @(posedge I_CLK or posedge I_POR_OR_BOR)
   begin
      if (I_POR_OR_BOR)
      begin
         for (int i = 0; i < CUST_DEPTH; i++)
         begin
            cust_reg[i] <= `ACC_CFG_UNPROGRAMMED;
         end
      end
      else
      begin
         cust_reg <= cust_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read paths.

   always_comb
   begin
      rdata_next = rdata_reg;
      info_next = info_reg;
      hit_next = 1'b0;
      if (I_SFR_RD)
      begin
         if (I_SFR_ADDR == `ACC_AUX_CONTROL_ADDR)
         begin
            rdata_next = aux_view;
         end
         else if (I_SFR_ADDR == SFR_DPH)
         begin
            rdata_next = dp_reg[sel][15:8];
         end
         else if (I_SFR_ADDR == SFR_DPL)
         begin
            rdata_next = dp_reg[sel][7:0];
         end
         else
         begin
            rdata_next = 8'h00;
         end
      end
      if (I_CODE_RD)
      begin
         hit_next = 1'b1;
         if (I_CODE_ADDR == `ACC_SIG_ADDR_0)
         begin
            info_next = SIG_BYTE_0;
         end
         else if (I_CODE_ADDR == `ACC_SIG_ADDR_1)
         begin
            info_next = SIG_BYTE_1;
         end
         else if (I_CODE_ADDR == `ACC_SIG_ADDR_2)
         begin
            info_next = SIG_BYTE_2;
         end
         else if (in_range(I_CODE_ADDR, `ACC_CUST_FIRST, `ACC_CUST_LAST))
         begin
            info_next = cust_reg[I_CODE_ADDR[4:0]];
         end
         else
         begin
            hit_next = 1'b0;
         end
      end
      else if (I_DATA_RD)
      begin
         hit_next = 1'b1;
         if (I_CODE_ADDR == `ACC_CFG_ONE_ADDR)
         begin
            info_next = cfg_one_reg;
         end
         else if (I_CODE_ADDR == `ACC_CFG_TWO_ADDR)
         begin
            info_next = cfg_two_reg;
         end
         else
         begin
            hit_next = 1'b0;
         end
      end
   end

   always_ff @(posedge I_CLK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
      begin
         rdata_reg <= 8'h00;
         info_reg <= 8'h00;
         hit_reg <= 1'b0;
      end
      else
      begin
         rdata_reg <= rdata_next;
         info_reg <= info_next;
         hit_reg <= hit_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign O_SFR_RDATA = rdata_reg;
   assign O_INFO_RDATA = info_reg;
   assign O_INFO_HIT = hit_reg;
   assign O_SOFT_RESET = soft_reset_bit_reg;
   assign O_KEYPAD_FLAG = aux_reg[`ACC_BIT_KEYPAD_FLAG];
   assign O_LOW_POWER_PROG_MEM = lpm_reg;
   assign O_BROWNOUT_DET_EN = ~aux_reg[`ACC_BIT_BROWNOUT_DISABLE];
   assign O_BROWNOUT_RESET = I_BROWNOUT_DET && O_BROWNOUT_DET_EN
                             && !aux_reg[`ACC_BIT_BROWNOUT_IRQ_MODE];
   assign O_BROWNOUT_IRQ = I_BROWNOUT_DET && O_BROWNOUT_DET_EN
                           && aux_reg[`ACC_BIT_BROWNOUT_IRQ_MODE];

   acc_cfg_decode u_cfg_decode
   (
      .i_cfg_one(cfg_one_reg),
      .i_cfg_two(cfg_two_reg),
      .o_watchdog_reset_enable(O_WATCHDOG_RESET_EN),
      .o_reset_pin_enable(O_RESET_PIN_EN),
      .o_port_reset_level(O_PORT_RESET_LEVEL),
      .o_brownout_threshold_sel(O_BROWNOUT_THRESHOLD_SEL),
      .o_clock_halving(O_CLOCK_HALVING),
      .o_clocks_per_cycle(O_CLOCKS_PER_CYCLE),
      .o_oscillator_type(O_OSCILLATOR_TYPE),
      .o_security(O_SECURITY)
   );
endmodule : acc_aux_control

// file: tb/acc_aux_control_props.sv
// Concurrent checks on the ports of the auxiliary control block.
`timescale 1ns/1ps
module acc_props
#(
   parameter logic [7:0] SIG_BYTE_0 = 8'h15 // Arbitrary value.
)
(
   // Clock and resets
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic I_POR_OR_BOR,
   // Register port
   input wire logic [7:0] I_SFR_ADDR,
   input wire logic I_SFR_WR,
   input wire logic [7:0] I_SFR_WDATA,
   // Pointer and reads
   input wire logic I_DP_INC,
   input wire logic I_DP_LOAD,
   input wire logic [15:0] O_DP,
   input wire logic I_CODE_RD,
   input wire logic [15:0] I_CODE_ADDR,
   input wire logic O_INFO_HIT,
   input wire logic [7:0] O_INFO_RDATA,
   // Events and controls
   input wire logic [7:0] I_KEYPAD_PINS,
   input wire logic [7:0] I_KEYPAD_EN,
   input wire logic I_BROWNOUT_DET,
   input wire logic O_SOFT_RESET,
   input wire logic O_BROWNOUT_DET_EN,
   input wire logic O_BROWNOUT_RESET,
   input wire logic O_BROWNOUT_IRQ,
   input wire logic O_LOW_POWER_PROG_MEM,
   input wire logic O_KEYPAD_FLAG
);
   logic wr_aux;
   assign wr_aux = I_SFR_WR && I_SFR_ADDR == 8'ha2;
   default clocking @(posedge I_CLK);
   endclocking
   default disable iff (I_SYS_RST);
   ////////////////////////////////////////////////////////////////////////////////
   soft_pulse_a: assert property (wr_aux && I_SFR_WDATA[3] |=> O_SOFT_RESET)
      else $error("soft reset pulse missing");
   soft_cause_a: assert property (O_SOFT_RESET |-> $past(wr_aux && I_SFR_WDATA[3]))
      else $error("soft reset without cause");
   key_set_a: assert property (|(I_KEYPAD_EN & ~I_KEYPAD_PINS) |=> O_KEYPAD_FLAG)
      else $error("keypad flag not set");
   key_hold_a: assert property (O_KEYPAD_FLAG && !(wr_aux && !I_SFR_WDATA[7]) |=> O_KEYPAD_FLAG)
      else $error("keypad flag lost");
   bod_ctl_a: assert property (wr_aux |=> O_BROWNOUT_DET_EN == !$past(I_SFR_WDATA[6]))
      else $error("brownout enable wrong");
   bo_route_a: assert property (O_BROWNOUT_RESET |-> I_BROWNOUT_DET && O_BROWNOUT_DET_EN && !O_BROWNOUT_IRQ)
      else $error("brownout reset misrouted");
   lp_keep_a: assert property (disable iff (I_POR_OR_BOR) O_LOW_POWER_PROG_MEM |=> O_LOW_POWER_PROG_MEM)
      else $error("low power bit cleared");
   dp_inc_a: assert property (I_DP_INC && !I_DP_LOAD && !I_SFR_WR |=> O_DP == $past(O_DP) + 16'h1)
      else $error("pointer increment wrong");
   sig_read_a: assert property (I_CODE_RD && I_CODE_ADDR == 16'hfc30 |=> O_INFO_HIT && O_INFO_RDATA == SIG_BYTE_0)
      else $error("signature byte wrong");
   cover property (O_SOFT_RESET);
   cover property ($rose(O_KEYPAD_FLAG));
   cover property (O_INFO_HIT);
endmodule : acc_props

bind acc_aux_control acc_props #(.SIG_BYTE_0(SIG_BYTE_0)) u_props (.I_CLK, .I_SYS_RST,
   .I_POR_OR_BOR, .I_SFR_ADDR, .I_SFR_WR, .I_SFR_WDATA, .I_DP_INC, .I_DP_LOAD, .O_DP,
   .I_CODE_RD, .I_CODE_ADDR, .O_INFO_HIT, .O_INFO_RDATA, .I_KEYPAD_PINS, .I_KEYPAD_EN,
   .I_BROWNOUT_DET, .O_SOFT_RESET, .O_BROWNOUT_DET_EN, .O_BROWNOUT_RESET, .O_BROWNOUT_IRQ,
   .O_LOW_POWER_PROG_MEM, .O_KEYPAD_FLAG);

// file: tb/acc_aux_control_tb.sv
// Self-checking bench of the auxiliary control block.
`timescale 1ns/1ps
module acc_aux_control_tb;
   // Arbitrary signature values.
   localparam logic [7:0] SIG [3] = '{8'h15, 8'h2a, 8'h3c};
   logic clk = 1'b0, rst = 1'b1, por = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, dp_inc = 1'b0;
   logic dp_ld = 1'b0, code_rd = 1'b0, data_rd = 1'b0, cust_wr = 1'b0, cfg_prog = 1'b0;
   logic bo_det = 1'b0, hit, soft_rst, bo_en, bo_rst, bo_irq, lp, kp_flag, wdt_en, pin_en;
   logic prt_lvl, brownout_threshold_sel, halve, sr_seen, got_hit, sel, lp_m;
   logic [7:0] sfr_addr = 8'h00, sfr_wd = 8'h00, acc = 8'h00, cfg1 = 8'hff, cfg2 = 8'hff;
   logic [7:0] cust_wd = 8'h00, kp_pins = 8'hff, kp_en = 8'h00, sfr_rdata, info, got, d, e1, e2;
   logic [15:0] dp_val = 16'h0000, code_addr = 16'h0000, dp, dp_idx, v;
   logic [15:0] ptr [2];
   logic [4:0] cust_wa = 5'h00;
   logic [3:0] cpc;
   logic [2:0] codes [7] = '{3'h7, 3'h3, 3'h2, 3'h1, 3'h0, 3'h5, 3'h7};
   acc_pkg::acc_osc_e osc;
   acc_pkg::acc_sec_e sec;
   int bad_count = 0, n_tests = 0, cycles = 0, op;

   acc_aux_control #(.SIG_BYTE_0(SIG[0]), .SIG_BYTE_1(SIG[1]), .SIG_BYTE_2(SIG[2])) DUT
   (
      .I_CLK(clk), .I_SYS_RST(rst), .I_POR_OR_BOR(por), .I_SFR_ADDR(sfr_addr),
      .I_SFR_WR(sfr_wr), .I_SFR_WDATA(sfr_wd), .I_SFR_RD(sfr_rd), .O_SFR_RDATA(sfr_rdata),
      .I_DP_INC(dp_inc), .I_DP_LOAD(dp_ld), .I_DP_LOAD_VALUE(dp_val), .I_ACC(acc), .O_DP(dp),
      .O_DP_INDEXED(dp_idx), .I_CODE_RD(code_rd), .I_CODE_ADDR(code_addr), .I_DATA_RD(data_rd),
      .O_INFO_HIT(hit), .O_INFO_RDATA(info), .I_CUST_WR(cust_wr), .I_CUST_WADDR(cust_wa),
      .I_CUST_WDATA(cust_wd), .I_CFG_ONE_NV(cfg1), .I_CFG_TWO_NV(cfg2),
      .I_CFG_PROGRAMMED(cfg_prog), .I_KEYPAD_PINS(kp_pins), .I_KEYPAD_EN(kp_en),
      .I_BROWNOUT_DET(bo_det), .O_SOFT_RESET(soft_rst), .O_BROWNOUT_DET_EN(bo_en),
      .O_BROWNOUT_RESET(bo_rst), .O_BROWNOUT_IRQ(bo_irq), .O_LOW_POWER_PROG_MEM(lp),
      .O_KEYPAD_FLAG(kp_flag), .O_WATCHDOG_RESET_EN(wdt_en), .O_RESET_PIN_EN(pin_en),
      .O_PORT_RESET_LEVEL(prt_lvl), .O_BROWNOUT_THRESHOLD_SEL(brownout_threshold_sel), .O_CLOCK_HALVING(halve),
      .O_CLOCKS_PER_CYCLE(cpc), .O_OSCILLATOR_TYPE(osc), .O_SECURITY(sec)
   );

   always #50 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic acc_pkg::acc_osc_e osc_exp(input logic [2:0] f);
      case (f)
         3'h7: return acc_pkg::ACC_OSC_EXT_CLK;
         3'h3: return acc_pkg::ACC_OSC_INT_RC;
         3'h2: return acc_pkg::ACC_OSC_LF_XTAL;
         3'h1: return acc_pkg::ACC_OSC_MF_XTAL;
         3'h0: return acc_pkg::ACC_OSC_HF_XTAL;
         default: return acc_pkg::ACC_OSC_RESERVED;
      endcase
   endfunction : osc_exp

   function automatic acc_pkg::acc_sec_e sec_exp(input logic [1:0] s);
      case (s)
         2'h3: return acc_pkg::ACC_SEC_OPEN;
         2'h2: return acc_pkg::ACC_SEC_NO_PROG;
         2'h0: return acc_pkg::ACC_SEC_NO_VERIFY;
         default: return acc_pkg::ACC_SEC_UNSUPPORTED;
      endcase
   endfunction : sec_exp

   // Bits 3 and 2 never hold; the low-power bit only accumulates.
   function automatic logic [7:0] aux_exp(input logic [7:0] w, input logic l);
      return {1'b0, w[6:5], l, 3'b000, w[0]};
   endfunction : aux_exp

   task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
      n_tests++;
      if (g !== e)
      begin
         bad_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] w);
      sfr_addr = a;
      sfr_wd = w;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
      sr_seen = soft_rst;
      @(negedge clk);
   endtask : sfr_write

   task automatic sfr_read(input logic [7:0] a);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      got = sfr_rdata;
      @(negedge clk);
   endtask : sfr_read

   task automatic mem_read(input logic c, input logic [15:0] a);
      code_addr = a;
      code_rd = c;
      data_rd = !c;
      @(negedge clk);
      code_rd = 1'b0;
      data_rd = 1'b0;
      got = info;
      got_hit = hit;
      @(negedge clk);
   endtask : mem_read

   task automatic dp_op(input logic l, input logic [15:0] w);
      dp_val = w;
      dp_ld = l;
      dp_inc = !l;
      @(negedge clk);
      dp_ld = 1'b0;
      dp_inc = 1'b0;
      @(negedge clk);
   endtask : dp_op

   task automatic power_up(input logic [7:0] c1, input logic [7:0] c2, input logic p);
      cfg1 = c1;
      cfg2 = c2;
      cfg_prog = p;
      por = 1'b1;
      rst = 1'b1;
      repeat (12) @(negedge clk);
      por = 1'b0;
      rst = 1'b0;
      repeat (3) @(negedge clk);
      sel = 1'b0;
      ptr = '{16'h0000, 16'h0000};
      lp_m = 1'b0;
   endtask : power_up

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         bad_count++;
         $display("[FAIL] %0t run hung", $time);
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'hb84d2a9c));
      foreach (codes[i])
      begin
         d = 8'($urandom());
         d[2:0] = codes[i];
         v = 16'($urandom());
         power_up(d, v[7:0], i != 6);
         e1 = (i != 6) ? d : 8'hff;
         e2 = (i != 6) ? v[7:0] : 8'hff;
         sfr_read(8'ha2);
         chk(got, 8'h00, "aux reset");
         chk(wdt_en, e1[7], "watchdog");
         chk(pin_en, e1[6], "reset pin");
         chk(prt_lvl, e1[5], "port level");
         chk(brownout_threshold_sel, e1[4], "threshold");
         chk(halve, !e1[3], "halving");
         chk(cpc, e1[3] ? 4'h6 : 4'hc, "cycle clocks");
         chk(osc, osc_exp(e1[2:0]), "oscillator");
         chk(sec, sec_exp(e2[7:6]), "security");
         mem_read(1'b0, 16'hfd00);
         chk({got_hit, got}, {1'b1, e1}, "cfg one read");
         mem_read(1'b0, 16'hfd01);
         chk(got, e2, "cfg two read");
         cfg1 = ~cfg1;
         @(negedge clk);
         chk(osc, osc_exp(e1[2:0]), "cfg locked");
         $display("test config %0d done", i);
      end
      repeat (8)
      begin
         d = 8'($urandom()) & 8'h75;
         bo_det = 1'($urandom());
         sfr_write(8'ha2, d);
         lp_m = lp_m | d[4];
         sfr_read(8'ha2);
         chk(got, aux_exp(d, lp_m), "aux readback");
         chk(lp, lp_m, "low power");
         chk(bo_en, !d[6], "brownout enable");
         chk(bo_irq, bo_det & !d[6] & d[5], "brownout irq");
         chk(bo_rst, bo_det & !d[6] & !d[5], "brownout reset");
      end
      sfr_write(8'ha2, 8'h10);
      sfr_write(8'ha2, 8'h00);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      sfr_read(8'ha2);
      chk(got, aux_exp(8'h00, 1'b1), "aux after reset");
      sfr_write(8'ha2, 8'h0d);
      chk(sr_seen, 1'b1, "soft reset");
      sfr_read(8'ha2);
      chk(got, aux_exp(8'h01, 1'b1), "soft reset bits");
      sfr_write(8'ha2, 8'h01);
      chk(sr_seen, 1'b0, "no soft reset");
      power_up(8'hff, 8'hff, 1'b0);
      chk(lp, 1'b0, "low power cleared");
      $display("test aux done");
      for (int i = 0; i < 40; i++)
      begin
         op = (i < 2) ? i : $urandom_range(4);
         v = (i == 0) ? 16'hffff : 16'($urandom());
         acc = 8'($urandom());
         if (op < 2) dp_op(op == 0, v);
         else if (op < 4) sfr_write(8'h80 + 8'(op), v[7:0]);
         else
         begin
            sfr_read(8'ha2);
            chk(got, {7'h00, sel}, "aux increment");
            sfr_write(8'ha2, got + 8'h01);
         end
         if (op == 0) ptr[sel] = v;
         else if (op == 1) ptr[sel] = ptr[sel] + 16'h1;
         else if (op == 2) ptr[sel][7:0] = v[7:0];
         else if (op == 3) ptr[sel][15:8] = v[7:0];
         else sel = !sel;
         chk(dp, ptr[sel], "pointer");
         chk(dp_idx, ptr[sel] + 16'(acc), "indexed");
         sfr_read(8'h83);
         chk(got, ptr[sel][15:8], "pointer high");
         sfr_read(8'h82);
         chk(got, ptr[sel][7:0], "pointer low");
      end
      $display("test pointers done");
      kp_en = {4'h0, 4'($urandom()) | 4'h1};
      kp_pins = 8'h7f;
      repeat (2) @(negedge clk);
      chk(kp_flag, 1'b0, "masked pin");
      kp_pins = 8'hfe;
      @(negedge clk);
      kp_pins = 8'hff;
      repeat (3) @(negedge clk);
      sfr_read(8'ha2);
      chk({kp_flag, got[7]}, 2'b11, "keypad flag held");
      sfr_write(8'ha2, {7'h00, sel});
      chk(kp_flag, 1'b0, "keypad clear");
      $display("test keypad done");
      for (int k = 0; k < 3; k++)
      begin
         mem_read(1'b1, (k == 2) ? 16'hfc60 : 16'hfc30 + 16'(k));
         chk({got_hit, got}, {1'b1, SIG[k]}, "signature");
      end
      mem_read(1'b1, 16'hfc32);
      chk(got_hit, 1'b0, "no hit");
      for (int i = 0; i < 4; i++)
      begin
         cust_wa = (i == 0) ? 5'h1f : 5'($urandom());
         cust_wd = 8'($urandom());
         mem_read(1'b1, 16'hfce0 + 16'(cust_wa));
         if (i == 0) chk(got, 8'hff, "blank customer");
         cust_wr = 1'b1;
         @(negedge clk);
         cust_wr = 1'b0;
         @(negedge clk);
         mem_read(1'b1, 16'hfce0 + 16'(cust_wa));
         chk({got_hit, got}, {1'b1, cust_wd}, "customer byte");
      end
      $display("test info reads done");
      conclude();
   end
endmodule : acc_aux_control_tb
